// *** hdl/rio_status.sv ***
//Function
// - One supply-pin short flag per channel, set while a short is seen.
// - Supply-pin short flag is valid in every channel mode.
// - Sensor-supply low flag set at or below 18 V.
// - Drive-power low flag set at or below 18 V.
// - Drive-power very-low flag at or below 11 V also forces the low flag.
// - Comm-started flag follows communication, IO-Link mode only.
// - Event flag set when the attached device raises an event, IO-Link only.
// - Event flag clears after all pending events were read acyclically, or when the channel leaves IO-Link.
// - Data-valid flag set while process data is valid, IO-Link only.
// - Data-valid flag low whenever no communication takes place.
// - Output lines follow the sixteen output bits, two per channel.
// - Comm-line output bit acts only in switched output mode.
// - Auxiliary output bit acts in IO-Link mode or when its own direction bit selects output.
// - One mode bit per channel: one selects IO-Link, zero switched.
// - IO-Link mode puts only the comm line into IO-Link; aux stays switched.
`timescale 1ns/1ps
`default_nettype none
`include "rio_map.svh"

module rio_status
   import rio_pkg::*;
#(
   parameter int NCH = 8
)(
   // Clock, reset, enable
   input  wire logic                   clk,
   input  wire logic                   rst,
   input  wire logic                   ce,
   // Register port
   input  wire logic [`RIO_ADDR_W-1:0] addr,
   input  wire logic [`RIO_DATA_W-1:0] wdata,
   input  wire logic                   wr,
   input  wire logic                   rd,
   output logic      [`RIO_DATA_W-1:0] rdata,
   // Interrupt
   output logic                        irq,
   // Supply monitor pins (asynchronous)
   input  wire logic [NCH-1:0]         supply_pin_short_in,
   input  wire logic                   sensor_supply_low_in,
   input  wire logic                   drive_power_low_in,
   input  wire logic                   drive_power_very_low_in,
   // IO-Link transceiver logic (same clock)
   input  wire logic [NCH-1:0]         comm_active,
   input  wire logic [NCH-1:0]         event_raise,
   input  wire logic [NCH-1:0]         events_all_read,
   input  wire logic [NCH-1:0]         pd_valid,
   // Cyclic link
   input  wire logic                   link_cycle,
   output logic      [NCH-1:0]         supply_pin_short_flags,
   output logic                        sensor_supply_low_flag,
   output logic                        drive_power_low_flag,
   output logic                        drive_power_very_low_flag,
   output logic      [NCH-1:0]         comm_started_flags,
   output logic      [NCH-1:0]         event_pending_flags,
   output logic      [NCH-1:0]         data_valid_flags,
   // Channel lines
   output logic      [NCH-1:0]         comm_line_drive,
   output logic      [NCH-1:0]         comm_line_iolink_en,
   output logic      [NCH-1:0]         aux_line_drive
);
   import rio_pkg::*;

   localparam int NSYNC = NCH + 3;

   // Refused at elaboration: the field map only has room for eight channels
   if (NCH < 1 || NCH > `RIO_MAX_CH) begin : g_bad_nch
      $error("rio_status: NCH must be 1 to 8");
   end

   function automatic logic hit(input logic [`RIO_ADDR_W-1:0] a,
                                input logic [`RIO_ADDR_W-1:0] off);
      hit = (a == off);
   endfunction : hit

   // ****************************************************************
   // Software registers
   // ****************************************************************
   logic [NCH-1:0]        channel_mode_commands;
   logic [2*NCH-1:0]      line_output_bits;
   logic [2*NCH-1:0]      line_dir;
   logic [`RIO_IRQ_W-1:0] irq_status;
   logic [`RIO_IRQ_W-1:0] irq_mask;
   logic [`RIO_IRQ_W-1:0] irq_set;
   logic [`RIO_IRQ_W-1:0] irq_clr;

   always_ff @(posedge clk) begin
      if (rst) begin
         channel_mode_commands <= NCH'(`RIO_MODE_RST);
      end else if (ce && wr && hit(addr, `RIO_REG_MODE)) begin
         channel_mode_commands <= wdata[NCH-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         line_output_bits <= (2*NCH)'(`RIO_OUT_RST);
      end else if (ce && wr && hit(addr, `RIO_REG_OUT)) begin
         line_output_bits <= wdata[2*NCH-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         line_dir <= (2*NCH)'(`RIO_DIR_RST);
      end else if (ce && wr && hit(addr, `RIO_REG_DIR)) begin
         line_dir <= wdata[2*NCH-1:0];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         irq_mask <= `RIO_IRQ_RST;
      end else if (ce && wr && hit(addr, `RIO_REG_IRQ_MASK)) begin
         irq_mask <= wdata[`RIO_IRQ_W-1:0];
      end
   end

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [NSYNC-1:0] sync_a;
   logic [NSYNC-1:0] sync_b;
   logic [NCH-1:0]   short_s;

   always_ff @(posedge clk) begin
      if (rst) begin
         sync_a <= '0;
         sync_b <= '0;
      end else if (ce) begin
         sync_a <= {drive_power_very_low_in, drive_power_low_in,
                    sensor_supply_low_in, supply_pin_short_in};
         sync_b <= sync_a;
      end
   end

   assign short_s = sync_b[NCH-1:0];

   // ****************************************************************
   // Supply flags
   // ****************************************************************
   logic sens_low;
   logic drv_low;
   logic drv_vlow;

   always_ff @(posedge clk) begin
      if (rst) begin
         sens_low <= 1'b0;
         drv_low  <= 1'b0;
         drv_vlow <= 1'b0;
      end else if (ce) begin
         sens_low <= sync_b[NCH];
         // The 11 V comparator also implies the 18 V condition
         drv_low  <= sync_b[NCH+1] | sync_b[NCH+2];
         drv_vlow <= sync_b[NCH+2];
      end
   end

   // ****************************************************************
   // Channels
   // ****************************************************************
   logic [NCH-1:0] short_f;
   logic [NCH-1:0] comm_f;
   logic [NCH-1:0] event_f;
   logic [NCH-1:0] valid_f;

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         rio_chan u_chan (
            .clk             (clk),
            .rst             (rst),
            .ce              (ce),
            .mode_iolink     (channel_mode_commands[g]),
            .comm_dir        (line_dir[2*g]),
            .aux_dir         (line_dir[2*g+1]),
            .comm_out_bit    (line_output_bits[2*g]),
            .aux_out_bit     (line_output_bits[2*g+1]),
            .short_s         (short_s[g]),
            .comm_active     (comm_active[g]),
            .event_raise     (event_raise[g]),
            .events_all_read (events_all_read[g]),
            .pd_valid        (pd_valid[g]),
            .mode            (),
            .short_flag      (short_f[g]),
            .comm_started    (comm_f[g]),
            .event_pending   (event_f[g]),
            .data_valid      (valid_f[g]),
            .comm_drive      (comm_line_drive[g]),
            .comm_iolink_en  (comm_line_iolink_en[g]),
            .aux_drive       (aux_line_drive[g])
         );
      end
   endgenerate

   // ****************************************************************
   // Cyclic input image
   // ****************************************************************
   // Image holds between link cycles so the master sees a coherent set
   always_ff @(posedge clk) begin
      if (rst) begin
         supply_pin_short_flags    <= '0;
         sensor_supply_low_flag    <= 1'b0;
         drive_power_low_flag      <= 1'b0;
         drive_power_very_low_flag <= 1'b0;
         comm_started_flags        <= '0;
         event_pending_flags       <= '0;
         data_valid_flags          <= '0;
      end else if (ce && link_cycle) begin
         supply_pin_short_flags    <= short_f;
         sensor_supply_low_flag    <= sens_low;
         drive_power_low_flag      <= drv_low;
         drive_power_very_low_flag <= drv_vlow;
         comm_started_flags        <= comm_f;
         event_pending_flags       <= event_f;
         data_valid_flags          <= valid_f;
      end
   end

   // ****************************************************************
   // Interrupts
   // ****************************************************************
   logic [NCH-1:0] short_q;
   logic [NCH-1:0] event_q;
   logic [2:0]     supply_q;

   always_ff @(posedge clk) begin
      if (rst) begin
         short_q  <= '0;
         event_q  <= '0;
         supply_q <= 3'h0;
      end else if (ce) begin
         short_q  <= short_f;
         event_q  <= event_f;
         supply_q <= {drv_vlow, drv_low, sens_low};
      end
   end

   always_comb begin
      irq_set = '0;
      irq_set[`RIO_I_SHORT +: NCH] = short_f & ~short_q;
      irq_set[`RIO_I_EVENT +: NCH] = event_f & ~event_q;
      irq_set[`RIO_I_SENS_LOW]     = sens_low & ~supply_q[0];
      irq_set[`RIO_I_DRV_LOW]      = drv_low & ~supply_q[1];
      irq_set[`RIO_I_DRV_VLOW]     = drv_vlow & ~supply_q[2];
      irq_clr = '0;
      if (wr && hit(addr, `RIO_REG_IRQ_STAT)) begin
         irq_clr = wdata[`RIO_IRQ_W-1:0];
      end
   end

   // A new event in the clearing cycle survives the clear
   always_ff @(posedge clk) begin
      if (rst) begin
         irq_status <= `RIO_IRQ_RST;
      end else if (ce) begin
         irq_status <= (irq_status & ~irq_clr) | irq_set;
      end
   end

   assign irq = |(irq_status & irq_mask);

   // ****************************************************************
   // Read port
   // ****************************************************************
   logic [`RIO_DATA_W-1:0] next_rdata;

   always_comb begin
      next_rdata = '0;
      case (addr)
         `RIO_REG_MODE: begin
            next_rdata[NCH-1:0] = channel_mode_commands;
         end
         `RIO_REG_OUT: begin
            next_rdata[2*NCH-1:0] = line_output_bits;
         end
         `RIO_REG_DIR: begin
            next_rdata[2*NCH-1:0] = line_dir;
         end
         `RIO_REG_FLAGS0: begin
            next_rdata[`RIO_F_SHORT +: NCH] = short_f;
            next_rdata[`RIO_F_SENS_LOW]     = sens_low;
            next_rdata[`RIO_F_DRV_LOW]      = drv_low;
            next_rdata[`RIO_F_DRV_VLOW]     = drv_vlow;
         end
         `RIO_REG_FLAGS1: begin
            next_rdata[`RIO_F_COMM +: NCH]  = comm_f;
            next_rdata[`RIO_F_EVENT +: NCH] = event_f;
            next_rdata[`RIO_F_VALID +: NCH] = valid_f;
         end
         `RIO_REG_IRQ_STAT: begin
            next_rdata[`RIO_IRQ_W-1:0] = irq_status;
         end
         `RIO_REG_IRQ_MASK: begin
            next_rdata[`RIO_IRQ_W-1:0] = irq_mask;
         end
         default: begin
            next_rdata = '0;
         end
      endcase
   end

   // Read data stand one cycle only, zero otherwise
   always_ff @(posedge clk) begin
      if (rst) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= rd ? next_rdata : '0;
      end
   end

endmodule : rio_status

`default_nettype wire

// *** hdl/rio_map.svh ***
`ifndef RIO_MAP_SVH
`define RIO_MAP_SVH

// ****************************************************************
// Register bus geometry
// ****************************************************************
`define RIO_ADDR_W        4
`define RIO_DATA_W        32

// ****************************************************************
// Register offsets (word addresses on the plain port)
// ****************************************************************
`define RIO_REG_MODE      4'h0
`define RIO_REG_OUT       4'h1
`define RIO_REG_DIR       4'h2
`define RIO_REG_FLAGS0    4'h3
`define RIO_REG_FLAGS1    4'h4
`define RIO_REG_IRQ_STAT  4'h5
`define RIO_REG_IRQ_MASK  4'h6

// ****************************************************************
// Field positions
// ****************************************************************
`define RIO_F_SHORT       0
`define RIO_F_SENS_LOW    8
`define RIO_F_DRV_LOW     9
`define RIO_F_DRV_VLOW    10
`define RIO_F_COMM        0
`define RIO_F_EVENT       8
`define RIO_F_VALID       16
`define RIO_I_SHORT       0
`define RIO_I_EVENT       8
`define RIO_I_SENS_LOW    16
`define RIO_I_DRV_LOW     17
`define RIO_I_DRV_VLOW    18
`define RIO_IRQ_W         19

// ****************************************************************
// Reset values and limits
// ****************************************************************
`define RIO_MODE_RST      32'h0
`define RIO_OUT_RST       32'h0
`define RIO_DIR_RST       32'h0
`define RIO_IRQ_RST       19'h0
`define RIO_MAX_CH        8

`endif

// *** hdl/rio_pkg.sv ***
package rio_pkg;

   // Operating mode of one channel, derived from mode and direction bits
   typedef enum logic [1:0] {
      RIO_MODE_SW_IN,
      RIO_MODE_SW_OUT,
      RIO_MODE_IOLINK
   } rio_mode_t;

endpackage : rio_pkg

// *** hdl/rio_chan.sv ***
`timescale 1ns/1ps
`default_nettype none

module rio_chan
   import rio_pkg::*;
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         ce,
   // Configuration
   input  wire logic         mode_iolink,
   input  wire logic         comm_dir,
   input  wire logic         aux_dir,
   input  wire logic         comm_out_bit,
   input  wire logic         aux_out_bit,
   // Line side status
   input  wire logic         short_s,
   input  wire logic         comm_active,
   input  wire logic         event_raise,
   input  wire logic         events_all_read,
   input  wire logic         pd_valid,
   // Results
   output rio_pkg::rio_mode_t mode,
   output logic              short_flag,
   output logic              comm_started,
   output logic              event_pending,
   output logic              data_valid,
   output logic              comm_drive,
   output logic              comm_iolink_en,
   output logic              aux_drive
);
   import rio_pkg::*;

   always_comb begin
      if (mode_iolink) begin
         mode = RIO_MODE_IOLINK;
      end else if (comm_dir) begin
         mode = RIO_MODE_SW_OUT;
      end else begin
         mode = RIO_MODE_SW_IN;
      end
   end

   // ****************************************************************
   // Status flags, sampled every clock
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         short_flag   <= 1'b0;
         comm_started <= 1'b0;
         data_valid   <= 1'b0;
      end else if (ce) begin
         short_flag   <= short_s;
         comm_started <= mode_iolink & comm_active;
         data_valid   <= mode_iolink & comm_active & pd_valid;
      end
   end

   // A raise in the same cycle as the final read keeps the flag up
   always_ff @(posedge clk) begin
      if (rst) begin
         event_pending <= 1'b0;
      end else if (ce) begin
         case (mode)
            RIO_MODE_IOLINK: begin
               if (event_raise) begin
                  event_pending <= 1'b1;
               end else if (events_all_read) begin
                  event_pending <= 1'b0;
               end
            end
            default: begin
               event_pending <= 1'b0;
            end
         endcase
      end
   end

   // ****************************************************************
   // Line drivers
   // ****************************************************************
   always_ff @(posedge clk) begin
      if (rst) begin
         comm_drive     <= 1'b0;
         comm_iolink_en <= 1'b0;
         aux_drive      <= 1'b0;
      end else if (ce) begin
         comm_drive     <= (mode == RIO_MODE_SW_OUT) & comm_out_bit;
         comm_iolink_en <= mode_iolink;
         // Auxiliary line stays switched even in IO-Link mode
         aux_drive      <= (mode_iolink | aux_dir) & aux_out_bit;
      end
   end

endmodule : rio_chan

`default_nettype wire

// *** testbench/rio_status_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rio_map.svh"

module rio_status_asserts #(
   parameter int NCH = 8
)(
   // Clock, reset and register port
   input wire logic                   clk,
   input wire logic                   rst,
   input wire logic                   ce,
   input wire logic [`RIO_ADDR_W-1:0] addr,
   input wire logic [`RIO_DATA_W-1:0] wdata,
   input wire logic                   wr,
   input wire logic                   rd,
   input wire logic [`RIO_DATA_W-1:0] rdata,
   // Supply pins and link image
   input wire logic [NCH-1:0]         supply_pin_short_in,
   input wire logic                   sensor_supply_low_in,
   input wire logic                   drive_power_low_in,
   input wire logic                   drive_power_very_low_in,
   input wire logic                   link_cycle,
   input wire logic [NCH-1:0]         supply_pin_short_flags,
   input wire logic                   sensor_supply_low_flag,
   input wire logic                   drive_power_low_flag,
   input wire logic                   drive_power_very_low_flag,
   input wire logic [NCH-1:0]         comm_started_flags,
   input wire logic [NCH-1:0]         data_valid_flags,
   // Channel lines
   input wire logic [NCH-1:0]         comm_line_drive,
   input wire logic [NCH-1:0]         comm_line_iolink_en
);
   // ********
   // Helper state
   // ********
   logic [NCH+2:0] pins, pins_q, img, exp_img;
   logic [2:0]     calm;
   logic [NCH-1:0] mode_wr;
   assign pins = {supply_pin_short_in, sensor_supply_low_in, drive_power_low_in,
                  drive_power_very_low_in};
   assign img = {supply_pin_short_flags, sensor_supply_low_flag, drive_power_low_flag,
                 drive_power_very_low_flag};
   assign exp_img = {pins[NCH+2:2], pins[1] | pins[0], pins[0]};
   // A capture only counts once the pins have crossed the synchroniser
   always_ff @(posedge clk) begin
      pins_q <= pins;
      if (rst || pins != pins_q) calm <= 3'h0;
      else if (calm != 3'h7) calm <= calm + 3'h1;
   end
   always_ff @(posedge clk) begin
      if (rst) mode_wr <= '0;
      else if (ce && wr && addr == `RIO_REG_MODE) mode_wr <= wdata[NCH-1:0];
   end
   // ********
   // Properties
   // ********
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst || !ce);
   sequence s_settled_capture;
      link_cycle && calm >= 3'h3;
   endsequence
   sequence s_mode_write;
      wr && addr == `RIO_REG_MODE;
   endsequence
   image_follows_pins_a:
      assert property (s_settled_capture |=> img == $past(exp_img))
      else $error("image differs from settled supply pins");
   very_low_forces_a:
      assert property (drive_power_very_low_flag |-> drive_power_low_flag)
      else $error("very low drive flag without low flag");
   image_holds_a:
      assert property (!link_cycle |=> $stable(img) && $stable(comm_started_flags)
                       && $stable(data_valid_flags))
      else $error("image changed outside a link cycle");
   valid_needs_comm_a:
      assert property ((data_valid_flags & ~comm_started_flags) == '0)
      else $error("data valid without communication");
   comm_drive_sw_a:
      assert property ((comm_line_drive & comm_line_iolink_en) == '0)
      else $error("comm line driven while in IO-Link operation");
   mode_write_a:
      assert property (s_mode_write |-> ##[1:2] comm_line_iolink_en == mode_wr)
      else $error("IO-Link enable does not follow mode write");
   mode_readback_a:
      assert property (rd && addr == `RIO_REG_MODE |=> rdata == `RIO_DATA_W'(mode_wr))
      else $error("mode readback wrong");
   unmapped_zero_a:
      assert property (rd && addr > `RIO_REG_IRQ_MASK |=> rdata == '0)
      else $error("unmapped read not zero");
endmodule : rio_status_asserts

bind rio_status rio_status_asserts #(.NCH(NCH)) u_asserts (
   .clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .supply_pin_short_in,
   .sensor_supply_low_in, .drive_power_low_in, .drive_power_very_low_in, .link_cycle,
   .supply_pin_short_flags, .sensor_supply_low_flag, .drive_power_low_flag,
   .drive_power_very_low_flag, .comm_started_flags, .data_valid_flags, .comm_line_drive,
   .comm_line_iolink_en
);

`default_nettype wire

// *** testbench/rio_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module rio_master_model #(
   parameter int NCH = 8,
   parameter int PER = 8
)(
   // Clock and reset
   input  wire logic           clk,
   input  wire logic           rst,
   // Image and acyclic reads
   input  wire logic           ack_en,
   input  wire logic [NCH-1:0] event_pending_flags,
   output logic                link_cycle,
   output logic      [NCH-1:0] events_all_read
);
   // ********
   // Cyclic refresh and event readout
   // ********
   int cnt;
   always_ff @(posedge clk) begin
      if (rst) begin
         cnt <= 0;
         link_cycle <= 1'b0;
      end else begin
         cnt <= (cnt == PER - 1) ? 0 : cnt + 1;
         link_cycle <= (cnt == PER - 1);
      end
   end
   // Reads only what the image last reported, so a late event is never lost
   always_ff @(posedge clk) begin
      if (rst) events_all_read <= '0;
      else events_all_read <= (ack_en && link_cycle) ? event_pending_flags : '0;
   end
endmodule : rio_master_model

`default_nettype wire

// *** testbench/rio_status_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rio_map.svh"

module rio_status_tb;
   import rio_pkg::*;
   localparam int NCH = 8;
   // ********
   // Bench signals
   // ********
   logic           clk;
   logic           rst = 1'b1;
   logic           ce = 1'b1;
   logic           wr = 1'b0;
   logic           rd = 1'b0;
   logic           ack_en = 1'b0;
   logic           sens = 1'b0;
   logic           low = 1'b0;
   logic           vlow = 1'b0;
   logic [3:0]     addr = 4'h0;
   logic [31:0]    wdata = 32'h0;
   logic [NCH-1:0] shorts = '0;
   logic [NCH-1:0] comm = '0;
   logic [NCH-1:0] raise = '0;
   logic [NCH-1:0] pdv = '0;
   logic [31:0]    rdata;
   logic           irq, link_cycle, sens_f, low_f, vlow_f;
   logic [NCH-1:0] ev_rd, short_f, comm_f, ev_f, dv_f, comm_drv, comm_iol, aux_drv;
   int             err_count = 0;
   int             cmp_count = 0;

   rio_status #(.NCH(NCH)) dut (
      .clk, .rst, .ce, .addr, .wdata, .wr, .rd, .rdata, .irq,
      .supply_pin_short_in(shorts), .sensor_supply_low_in(sens),
      .drive_power_low_in(low), .drive_power_very_low_in(vlow),
      .comm_active(comm), .event_raise(raise), .events_all_read(ev_rd), .pd_valid(pdv),
      .link_cycle, .supply_pin_short_flags(short_f), .sensor_supply_low_flag(sens_f),
      .drive_power_low_flag(low_f), .drive_power_very_low_flag(vlow_f),
      .comm_started_flags(comm_f), .event_pending_flags(ev_f), .data_valid_flags(dv_f),
      .comm_line_drive(comm_drv), .comm_line_iolink_en(comm_iol), .aux_line_drive(aux_drv));

   rio_master_model #(.NCH(NCH), .PER(8)) u_master (
      .clk, .rst, .ack_en, .event_pending_flags(ev_f), .link_cycle,
      .events_all_read(ev_rd));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ********
   // Tasks
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, exp);
   endtask : rd_chk

   task automatic lines(input logic [7:0] d, input logic [7:0] e, input logic [7:0] x);
      repeat (2) @(posedge clk);
      #1 chk(32'({comm_drv, comm_iol, aux_drv}), {8'h0, d, e, x});
   endtask : lines

   // Three full link periods of eight clocks: synchroniser, image capture and the event readout
   task automatic refresh;
      repeat (24) @(posedge clk);
      #1;
   endtask : refresh

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : report_and_stop

   // ********
   // Tests
   // ********
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      for (int a = 0; a < 16; a++) rd_chk(a[3:0], 32'h0);
      $display("test reset values done");
      wr_reg(`RIO_REG_MODE, 32'h0f);
      wr_reg(`RIO_REG_DIR, 32'hffff);
      wr_reg(`RIO_REG_OUT, 32'hffff);
      lines(8'hf0, 8'h0f, 8'hff);
      wr_reg(`RIO_REG_DIR, 32'h0);
      lines(8'h00, 8'h0f, 8'h0f);
      wr_reg(`RIO_REG_DIR, 32'hffff);
      wr_reg(`RIO_REG_OUT, 32'h5555);
      lines(8'hf0, 8'h0f, 8'h00);
      // A write while the enable is low must leave every line as it was
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(`RIO_REG_OUT, 32'h0);
      ce <= 1'b1;
      lines(8'hf0, 8'h0f, 8'h00);
      rd_chk(`RIO_REG_MODE, 32'h0f);
      $display("test line outputs done");
      @(posedge clk);
      shorts <= 8'ha5;
      sens <= 1'b1;
      vlow <= 1'b1;
      refresh();
      chk(32'({short_f, sens_f, low_f, vlow_f}), 32'h52f);
      rd_chk(`RIO_REG_FLAGS0, 32'h7a5);
      @(posedge clk);
      shorts <= '0;
      sens <= 1'b0;
      vlow <= 1'b0;
      low <= 1'b1;
      refresh();
      chk(32'({short_f, sens_f, low_f, vlow_f}), 32'h2);
      rd_chk(`RIO_REG_IRQ_STAT, 32'h700a5);
      wr_reg(`RIO_REG_IRQ_MASK, 32'h1);
      #1 chk(32'(irq), 32'h1);
      wr_reg(`RIO_REG_IRQ_STAT, 32'h1);
      @(posedge clk);
      #1 chk(32'(irq), 32'h0);
      rd_chk(`RIO_REG_IRQ_STAT, 32'h700a4);
      $display("test supply flags done");
      @(posedge clk);
      comm <= 8'hff;
      pdv <= 8'h33;
      raise <= 8'h81;
      @(posedge clk);
      raise <= 8'h00;
      refresh();
      chk(32'({comm_f, ev_f, dv_f}), 32'h0f0103);
      rd_chk(`RIO_REG_FLAGS1, 32'h03010f);
      refresh();
      chk(32'(ev_f), 32'h01);
      @(posedge clk);
      ack_en <= 1'b1;
      refresh();
      chk(32'(ev_f), 32'h00);
      @(posedge clk);
      comm <= '0;
      refresh();
      chk(32'({comm_f, dv_f}), 32'h0);
      $display("test IO-Link flags done");
      report_and_stop();
   end

   initial begin
      repeat (4000) @(posedge clk);
      err_count++;
      report_and_stop();
   end
endmodule : rio_status_tb

`default_nettype wire
